/* File: rtl/hsfp_regs_map.vh */
/*
 Register offsets, field positions, reset values and timing constants for
 the status and fabric-protect register bank.
 Assumes a 32-bit AHB-Lite register bus with one register per aligned word.
*/
`ifndef HSFP_REGS_MAP_VH
`define HSFP_REGS_MAP_VH

`define HSFP_OFS_IO_CAL 12'h000
`define HSFP_OFS_CLK_CAL 12'h004
`define HSFP_OFS_PROT_SIZE 12'h008
`define HSFP_OFS_PROT_BASE 12'h00c
`define HSFP_OFS_SRAM_ERR 12'h010
`define HSFP_OFS_INT_SR 12'h014
`define HSFP_OFS_EXT_SR 12'h018
`define HSFP_OFS_CNT_CLR 12'h01c
`define HSFP_OFS_FLUSH 12'h020
`define HSFP_OFS_EXT_CLR 12'h024
`define HSFP_OFS_INT_CLR 12'h028
`define HSFP_OFS_SRAM_CLR 12'h02c

`define HSFP_ADDR_W 12
`define HSFP_SIZE_RST 6'h1e
`define HSFP_CODE_RST 7'h7f
`define HSFP_NCODE_RST 5'h1f
`define HSFP_PCODE_HI 12
`define HSFP_PCODE_LO 6
`define HSFP_NCODE_HI 5
`define HSFP_NCODE_LO 1
`define HSFP_LOCK_MID_BIT 17
`define HSFP_LCKOUT_BIT 16
`define HSFP_DMA_WERR_BIT 15
`define HSFP_AHB_WERR_BIT 14
`define HSFP_MATCH_LO 7
`define HSFP_FLUSH_AHB_BIT 4
`define HSFP_FLUSH_DMA_BIT 3
`define HSFP_INV_DMA_BIT 7
`define HSFP_INV_AHB_BIT 6
`define HSFP_LOCK_CNT_W 20
`define HSFP_LOCK_CNT_MAX 20'hfffff
`define HSFP_BUSERR_MASK 7'h57
`define HSFP_HTRANS_NONSEQ 2'h2

`endif

/* File: rtl/hsfp_regs.v */
/*
 Status and fabric-protect register bank of the memory subsystem, with its
 AHB-Lite slave, DDR bridge lock-timeout counter and protection check.
 Assumes one clock; pin-level inputs from other domains are synchronised here.
*/
// The register offsets and the AHB-Lite register port were decided locally.
`timescale 1ns/1ps
`include "hsfp_regs_map.vh"

// Overview of operation
// [RULE_01] First calibration after reset locks codes one cycle after done interrupt.
// [RULE_02] Later runs lock codes only on self-refresh or fabric override.
// [RULE_03] Pull-up code in bits 12:6, pull-down in 5:1, both reset to ones.
// [RULE_04] Fabric clock calibration fail bit reads 1 when failing.
// [RULE_05] Six-bit protected size field resets to 11110.
// [RULE_06] Size code n gives 2 to n+1 bytes; other codes reserved.
// [RULE_07] Protect enable clear leaves fabric masters unrestricted.
// [RULE_08] Enabled, fabric accesses inside region get an error response.
// [RULE_09] Only base bits 31 down to N are compared.
// [RULE_10] Per SRAM bank, separate double and corrected single error flags.
// [RULE_11] Lock gained and lost flags on PLL lock edges.
// [RULE_12] Bits 4 to 6 flag calibration done, SECDED and fabric interface irq.
// [RULE_13] Twenty-bit lock counter sets sticky timeout flag at its maximum.
// [RULE_14] Bit 17 records the timeout master: 0 AHB, 1 DMA.
// [RULE_15] Bits 15 and 14 flag DMA and AHB write errors with addresses.
// [RULE_16] Address match error sets bit 0, upper five bits zero.
// [RULE_17] Per-master bus error field: bits 0,1,2,4,6.
// [RULE_18] Clear bits pulse clears of SRAM error counters.
// [RULE_19] Bits 4 and 3 pulse AHB and DMA write buffer flushes.
// [RULE_20] Bits 7 and 6 pulse DMA and AHB read buffer invalidates.
// [RULE_21] Every clear, flush and invalidate is a single-cycle pulse.
module hsfp_regs
(
    // Clock, reset and enable.
    input wire hclk,
    input wire hresetn,
    input wire clk_en,
    // AHB-Lite slave.
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    // I/O calibration.
    input wire io_cal_done_irq,
    input wire dram_self_refresh,
    input wire fabric_cal_override,
    input wire [6:0] pullup_code_in,
    input wire [4:0] pulldown_code_in,
    input wire fabric_clk_cal_failed_in,
    // PLL lock pins.
    input wire main_pll_lock,
    input wire fabric_pll_lock,
    // Event sources.
    input wire [3:0] sram_err_evt,
    input wire ddr_cal_done_irq,
    input wire ddr_secded_irq,
    input wire ddr_fabric_if_irq,
    input wire lock_xfer_active,
    input wire lock_xfer_dma,
    input wire dma_write_err_evt,
    input wire [31:0] dma_err_addr_in,
    input wire ahb_write_err_evt,
    input wire [31:0] ahb_err_addr_in,
    input wire addr_match_evt,
    input wire [6:0] bus_err_evt,
    // Fabric master protection check.
    input wire fab_req,
    input wire [31:0] fab_addr,
    output reg fab_prot_err,
    // Error address readouts.
    output reg [31:0] dma_error_address,
    output reg [31:0] ahb_error_address,
    // Control pulses.
    output reg sram0_single_cnt_clear,
    output reg sram0_double_cnt_clear,
    output reg sram1_single_cnt_clear,
    output reg sram1_double_cnt_clear,
    output reg dma_write_buf_flush,
    output reg ahb_write_buf_flush,
    output reg ahb_read_buf_invalidate,
    output reg dma_read_buf_invalidate
);

    // Size code to region exponent; zero marks a reserved code.
    function [5:0] size_exp;
        input [4:0] code;
        begin
            case (code)
                5'h0a, 5'h06: size_exp = {1'b0, code} + 6'h01; // RULE_06
                5'h0d, 5'h0e, 5'h0f: size_exp = {1'b0, code} + 6'h01;
                5'h10, 5'h11, 5'h12, 5'h16: size_exp = {1'b0, code} + 6'h01;
                default: size_exp = 6'h00;
            endcase
        end
    endfunction

    // Three-stage synchronisers for pin-level inputs.
    reg [2:0] main_pll_sync_ff;
    reg [2:0] fpll_sync_ff;
    reg [2:0] ccf_sync_ff;
    reg main_pll_state_ff;
    reg fpll_state_ff;
    reg ccf_state_ff;

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            main_pll_sync_ff <= 3'h0;
            fpll_sync_ff <= 3'h0;
            ccf_sync_ff <= 3'h0;
            main_pll_state_ff <= 1'b0;
            fpll_state_ff <= 1'b0;
            ccf_state_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            main_pll_sync_ff <= {main_pll_sync_ff[1:0], main_pll_lock};
            fpll_sync_ff <= {fpll_sync_ff[1:0], fabric_pll_lock};
            ccf_sync_ff <= {ccf_sync_ff[1:0], fabric_clk_cal_failed_in};
            if (main_pll_sync_ff[1] == main_pll_sync_ff[2])
                main_pll_state_ff <= main_pll_sync_ff[2];
            if (fpll_sync_ff[1] == fpll_sync_ff[2])
                fpll_state_ff <= fpll_sync_ff[2];
            if (ccf_sync_ff[1] == ccf_sync_ff[2])
                ccf_state_ff <= ccf_sync_ff[2];
        end
    end

    wire main_pll_next = (main_pll_sync_ff[1] == main_pll_sync_ff[2]) ? main_pll_sync_ff[2] : main_pll_state_ff;
    wire fpll_next = (fpll_sync_ff[1] == fpll_sync_ff[2]) ? fpll_sync_ff[2] : fpll_state_ff;

    // Bus address phase capture.
    reg wr_pend_ff;
    reg [`HSFP_ADDR_W-1:0] wr_addr_ff;
    wire addr_ok = hsel && hready && (htrans == `HSFP_HTRANS_NONSEQ || htrans[1]);
    wire [`HSFP_ADDR_W-1:0] a_ofs = {haddr[`HSFP_ADDR_W-1:2], 2'b00};
    wire wr_now = wr_pend_ff;
    wire [`HSFP_ADDR_W-1:0] w_ofs = wr_addr_ff;

    function wr_hit;
        input [`HSFP_ADDR_W-1:0] ofs;
        input [`HSFP_ADDR_W-1:0] target;
        input en;
        begin
            wr_hit = en && (ofs == target);
        end
    endfunction

    // Register state.
    reg [5:0] prot_size_ff;
    reg [31:0] prot_base_ff;
    reg [6:0] pcode_ff;
    reg [4:0] ncode_ff;
    reg codes_locked_flag_ff;
    reg first_run_done_ff;
    reg cal_irq_d_ff;
    reg [3:0] sram_err_ff;
    reg [6:0] int_sr_ff;
    reg lock_timeout_flag_ff;
    reg lock_timeout_master_ff;
    reg dma_write_error_ff;
    reg ahb_write_error_ff;
    reg addr_match_error_ff;
    reg [6:0] bus_error_per_master_ff;
    reg [`HSFP_LOCK_CNT_W-1:0] lock_cnt_ff;

    wire [5:0] exp_n = size_exp(prot_size_ff[4:0]);
    wire [31:0] cmp_mask = (exp_n == 6'h00) ? 32'h0 : (32'hffffffff << exp_n[4:0]);
    wire prot_hit = prot_base_ff[0] && (exp_n != 6'h00) // RULE_07
        && ((fab_addr & cmp_mask) == (prot_base_ff & cmp_mask)); // RULE_09

    wire [31:0] wd = hwdata;
    wire wr_ext_clr = wr_hit(w_ofs, `HSFP_OFS_EXT_CLR, wr_now);
    wire wr_int_clr = wr_hit(w_ofs, `HSFP_OFS_INT_CLR, wr_now);
    wire wr_sram_clr = wr_hit(w_ofs, `HSFP_OFS_SRAM_CLR, wr_now);
    wire wr_cnt_clr = wr_hit(w_ofs, `HSFP_OFS_CNT_CLR, wr_now);
    wire wr_flush = wr_hit(w_ofs, `HSFP_OFS_FLUSH, wr_now);
    wire lock_max = lock_xfer_active && (lock_cnt_ff == `HSFP_LOCK_CNT_MAX);

    // Read mux.
    reg [31:0] rd_mux;
    always @*
    begin
        case (a_ofs)
            `HSFP_OFS_IO_CAL: rd_mux = {19'h0, pcode_ff, ncode_ff, codes_locked_flag_ff}; // RULE_03
            `HSFP_OFS_CLK_CAL: rd_mux = {31'h0, ccf_state_ff}; // RULE_04
            `HSFP_OFS_PROT_SIZE: rd_mux = {26'h0, prot_size_ff};
            `HSFP_OFS_PROT_BASE: rd_mux = prot_base_ff;
            `HSFP_OFS_SRAM_ERR: rd_mux = {28'h0, sram_err_ff};
            `HSFP_OFS_INT_SR: rd_mux = {25'h0, int_sr_ff};
            `HSFP_OFS_EXT_SR: rd_mux = {14'h0, lock_timeout_master_ff, lock_timeout_flag_ff,
                dma_write_error_ff, ahb_write_error_ff, 1'b0, 5'h00, addr_match_error_ff,
                bus_error_per_master_ff}; // RULE_16
            default: rd_mux = 32'h0;
        endcase
    end

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= {`HSFP_ADDR_W{1'b0}};
            hrdata <= 32'h0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            prot_size_ff <= `HSFP_SIZE_RST; // RULE_05
            prot_base_ff <= 32'h0;
            pcode_ff <= `HSFP_CODE_RST;
            ncode_ff <= `HSFP_NCODE_RST;
            codes_locked_flag_ff <= 1'b0;
            first_run_done_ff <= 1'b0;
            cal_irq_d_ff <= 1'b0;
            sram_err_ff <= 4'h0;
            int_sr_ff <= 7'h00;
            lock_timeout_flag_ff <= 1'b0;
            lock_timeout_master_ff <= 1'b0;
            dma_write_error_ff <= 1'b0;
            ahb_write_error_ff <= 1'b0;
            addr_match_error_ff <= 1'b0;
            bus_error_per_master_ff <= 7'h00;
            lock_cnt_ff <= {`HSFP_LOCK_CNT_W{1'b0}};
            fab_prot_err <= 1'b0;
            dma_error_address <= 32'h0;
            ahb_error_address <= 32'h0;
            sram0_single_cnt_clear <= 1'b0;
            sram0_double_cnt_clear <= 1'b0;
            sram1_single_cnt_clear <= 1'b0;
            sram1_double_cnt_clear <= 1'b0;
            dma_write_buf_flush <= 1'b0;
            ahb_write_buf_flush <= 1'b0;
            ahb_read_buf_invalidate <= 1'b0;
            dma_read_buf_invalidate <= 1'b0;
        end
        else if (clk_en)
        begin
            // Reads answer with zero wait states; hrdata is registered here.
            wr_pend_ff <= addr_ok && hwrite;
            wr_addr_ff <= a_ofs;
            if (addr_ok && !hwrite)
                hrdata <= rd_mux;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (wr_hit(w_ofs, `HSFP_OFS_PROT_SIZE, wr_now))
                prot_size_ff <= wd[5:0];
            if (wr_hit(w_ofs, `HSFP_OFS_PROT_BASE, wr_now))
                prot_base_ff <= wd;

            // Codes track the calibrator until locked, then freeze.
            cal_irq_d_ff <= io_cal_done_irq;
            if (!codes_locked_flag_ff)
            begin
                pcode_ff <= pullup_code_in;
                ncode_ff <= {2'b00, pulldown_code_in} == 7'h0 ? 5'h00 : pulldown_code_in;
            end
            if (io_cal_done_irq && !cal_irq_d_ff && first_run_done_ff)
                codes_locked_flag_ff <= 1'b0;
            if (cal_irq_d_ff && !first_run_done_ff)
            begin
                codes_locked_flag_ff <= 1'b1; // RULE_01
                first_run_done_ff <= 1'b1;
            end
            else if (first_run_done_ff && (dram_self_refresh || fabric_cal_override))
                codes_locked_flag_ff <= 1'b1; // RULE_02

            // Sticky flags: software writes ones to clear; a new event wins.
            sram_err_ff <= (sram_err_ff & ~(wr_sram_clr ? wd[3:0] : 4'h0)) | sram_err_evt; // RULE_10
            int_sr_ff <= (int_sr_ff & ~(wr_int_clr ? wd[6:0] : 7'h00)) | {ddr_fabric_if_irq,
                ddr_secded_irq, ddr_cal_done_irq, // RULE_12
                fpll_state_ff & ~fpll_next, ~fpll_state_ff & fpll_next,
                main_pll_state_ff & ~main_pll_next, ~main_pll_state_ff & main_pll_next}; // RULE_11

            // Lock counter runs only while a locked transfer holds the bus.
            if (!lock_xfer_active)
                lock_cnt_ff <= {`HSFP_LOCK_CNT_W{1'b0}};
            else if (!lock_max)
                lock_cnt_ff <= lock_cnt_ff + {{(`HSFP_LOCK_CNT_W-1){1'b0}}, 1'b1}; // RULE_13
            if (lock_max)
            begin
                lock_timeout_flag_ff <= 1'b1; // RULE_13
                lock_timeout_master_ff <= lock_xfer_dma; // RULE_14
            end
            else if (wr_ext_clr && wd[`HSFP_LCKOUT_BIT])
                lock_timeout_flag_ff <= 1'b0;

            if (dma_write_err_evt)
            begin
                dma_write_error_ff <= 1'b1; // RULE_15
                dma_error_address <= dma_err_addr_in;
            end
            else if (wr_ext_clr && wd[`HSFP_DMA_WERR_BIT])
                dma_write_error_ff <= 1'b0;
            if (ahb_write_err_evt)
            begin
                ahb_write_error_ff <= 1'b1; // RULE_15
                ahb_error_address <= ahb_err_addr_in;
            end
            else if (wr_ext_clr && wd[`HSFP_AHB_WERR_BIT])
                ahb_write_error_ff <= 1'b0;
            if (addr_match_evt)
                addr_match_error_ff <= 1'b1; // RULE_16
            else if (wr_ext_clr && wd[`HSFP_MATCH_LO])
                addr_match_error_ff <= 1'b0;
            bus_error_per_master_ff <= ((bus_error_per_master_ff
                & ~(wr_ext_clr ? wd[6:0] : 7'h00)) | bus_err_evt) & `HSFP_BUSERR_MASK; // RULE_17

            fab_prot_err <= fab_req && prot_hit; // RULE_08

            // Command pulses last one cycle and self-clear.
            sram0_single_cnt_clear <= wr_cnt_clr && wd[0]; // RULE_18
            sram0_double_cnt_clear <= wr_cnt_clr && wd[1]; // RULE_18
            sram1_single_cnt_clear <= wr_cnt_clr && wd[2]; // RULE_18
            sram1_double_cnt_clear <= wr_cnt_clr && wd[3]; // RULE_18
            ahb_write_buf_flush <= wr_flush && wd[`HSFP_FLUSH_AHB_BIT]; // RULE_19 RULE_21
            dma_write_buf_flush <= wr_flush && wd[`HSFP_FLUSH_DMA_BIT]; // RULE_19 RULE_21
            dma_read_buf_invalidate <= wr_flush && wd[`HSFP_INV_DMA_BIT]; // RULE_20 RULE_21
            ahb_read_buf_invalidate <= wr_flush && wd[`HSFP_INV_AHB_BIT]; // RULE_20 RULE_21
        end
    end

endmodule // hsfp_regs

/* File: dv/hsfp_ahb_master.sv */
/*
 AHB-Lite master model standing in for the processor or fabric master.
 Assumes one slave whose hreadyout is fed back as hready.
*/
`timescale 1ns/1ps
`include "hsfp_regs_map.vh"
module hsfp_ahb_master
(
    // Clock and answer.
    input wire hclk,
    input wire hready,
    input wire [31:0] hrdata,
    // Request.
    output reg hsel,
    output reg [31:0] haddr,
    output reg [1:0] htrans,
    output reg hwrite,
    output reg [2:0] hsize,
    output reg [31:0] hwdata
);
    initial
    begin
        {hsel, hwrite, htrans, hsize, haddr, hwdata} = 70'h0;
    end

    // Enter right after a rising edge; returns at the edge that ends the data phase.
    task xfer(input w, input [31:0] a, input [31:0] d, output [31:0] q);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= `HSFP_HTRANS_NONSEQ;
        hwrite <= w;
        hsize <= 3'h2;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        haddr <= ~a;
        hwdata <= w ? d : ~d;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        q = hrdata;
        // A released data bus must not look like valid data.
        hwdata <= ~d;
    endtask
endmodule // hsfp_ahb_master

/* File: dv/hsfp_regs_checker.sv */
/*
 Port-level assertions for the status and fabric-protect register bank.
 Assumes zero-wait AHB-Lite with clk_en held high.
*/
`timescale 1ns/1ps
`include "hsfp_regs_map.vh"
module hsfp_regs_checker
(
    // Bus.
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [31:0] hwdata,
    input wire hready,
    input wire [31:0] hrdata,
    input wire hreadyout,
    input wire hresp,
    // Protection and pulses.
    input wire fab_req,
    input wire fab_prot_err,
    input wire sram0_single_cnt_clear,
    input wire sram0_double_cnt_clear,
    input wire sram1_single_cnt_clear,
    input wire sram1_double_cnt_clear,
    input wire dma_write_buf_flush,
    input wire ahb_write_buf_flush,
    input wire ahb_read_buf_invalidate,
    input wire dma_read_buf_invalidate
);
    wire acc = hsel && hready && htrans[1];
    wire [11:0] ofs = haddr[11:0];
    wire rd = acc && !hwrite;
    wire wr_flush = acc && hwrite && ofs == `HSFP_OFS_FLUSH;
    wire wr_clr = acc && hwrite && ofs == `HSFP_OFS_CNT_CLR;
    wire ctl_wr = wr_flush || wr_clr;
    wire any_pls = |{sram0_single_cnt_clear, sram0_double_cnt_clear, sram1_single_cnt_clear,
        sram1_double_cnt_clear, dma_write_buf_flush, ahb_write_buf_flush,
        ahb_read_buf_invalidate, dma_read_buf_invalidate};
    default clocking dc @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_okay; hreadyout && !hresp; endproperty
    a_okay: assert property (p_okay) else $error("bus answer not zero-wait OKAY");
    property p_flush; wr_flush ##1 1'b1 |=>
        {ahb_write_buf_flush, dma_write_buf_flush} == $past(hwdata[4:3]); endproperty
    a_flush: assert property (p_flush) else $error("flush pulse mismatch");
    property p_inv; wr_flush ##1 1'b1 |=>
        {dma_read_buf_invalidate, ahb_read_buf_invalidate} == $past(hwdata[7:6]); endproperty
    a_inv: assert property (p_inv) else $error("invalidate pulse mismatch");
    property p_clr; wr_clr ##1 1'b1 |=> {sram1_double_cnt_clear, sram1_single_cnt_clear,
        sram0_double_cnt_clear, sram0_single_cnt_clear} == $past(hwdata[3:0]); endproperty
    a_clr: assert property (p_clr) else $error("counter clear pulse mismatch");
    property p_single; any_pls |-> $past(ctl_wr, 2); endproperty
    a_single: assert property (p_single) else $error("pulse without its write");
    property p_prot; fab_prot_err |-> $past(fab_req); endproperty
    a_prot: assert property (p_prot) else $error("error without fabric request");
    property p_ext; rd && ofs == `HSFP_OFS_EXT_SR |=> hrdata[31:18] == 14'h0
        && hrdata[13:8] == 6'h0 && hrdata[5] == 1'b0 && hrdata[3] == 1'b0; endproperty
    a_ext: assert property (p_ext) else $error("external status spare bits set");
    property p_int; rd && ofs == `HSFP_OFS_INT_SR |=> hrdata[31:7] == 25'h0; endproperty
    a_int: assert property (p_int) else $error("internal status spare bits set");
    property p_size; rd && ofs == `HSFP_OFS_PROT_SIZE |=> hrdata[31:6] == 26'h0; endproperty
    a_size: assert property (p_size) else $error("size register spare bits set");
    property p_clk; rd && ofs == `HSFP_OFS_CLK_CAL |=> hrdata[31:1] == 31'h0; endproperty
    a_clk: assert property (p_clk) else $error("clock cal spare bits set");
    property p_sram; rd && ofs == `HSFP_OFS_SRAM_ERR |=> hrdata[31:4] == 28'h0; endproperty
    a_sram: assert property (p_sram) else $error("sram status spare bits set");
endmodule // hsfp_regs_checker

bind hsfp_regs hsfp_regs_checker u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hwdata, .hready, .hrdata, .hreadyout, .hresp, .fab_req, .fab_prot_err,
    .sram0_single_cnt_clear, .sram0_double_cnt_clear, .sram1_single_cnt_clear,
    .sram1_double_cnt_clear, .dma_write_buf_flush, .ahb_write_buf_flush,
    .ahb_read_buf_invalidate, .dma_read_buf_invalidate);

/* File: dv/hsfp_regs_bench.sv */
/*
 Self-checking bench for the status and fabric-protect register bank.
 Assumes the master model and checker files are compiled first.
*/
`timescale 1ns/1ps
`include "hsfp_regs_map.vh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin num_errors++; $display("[ERR] %0t: got %h exp %h", $time, (g), (e)); end end
module hsfp_regs_bench;
    reg hclk = 1'b0, hresetn = 1'b0, clk_en = 1'b1;
    reg io_cal_done_irq = 0, dram_self_refresh = 0, fabric_cal_override = 0;
    reg [6:0] pullup_code_in = 7'h7f;
    reg [4:0] pulldown_code_in = 5'h1f;
    reg fabric_clk_cal_failed_in = 0, main_pll_lock = 0, fabric_pll_lock = 0;
    reg [3:0] sram_err_evt = 4'h0;
    reg ddr_cal_done_irq = 0, ddr_secded_irq = 0, ddr_fabric_if_irq = 0;
    reg lock_xfer_active = 0, lock_xfer_dma = 0, dma_write_err_evt = 0, ahb_write_err_evt = 0;
    reg addr_match_evt = 0, fab_req = 0;
    reg [31:0] dma_err_addr_in = 0, ahb_err_addr_in = 0, fab_addr = 0;
    reg [6:0] bus_err_evt = 7'h0;
    wire hsel, hwrite, hreadyout, hresp, fab_prot_err;
    wire [31:0] haddr, hwdata, hrdata, dma_error_address, ahb_error_address;
    wire [1:0] htrans;
    wire [2:0] hsize;
    wire sram0_single_cnt_clear, sram0_double_cnt_clear, sram1_single_cnt_clear;
    wire sram1_double_cnt_clear, dma_write_buf_flush, ahb_write_buf_flush;
    wire ahb_read_buf_invalidate, dma_read_buf_invalidate;
    int num_errors = 0, compares = 0, cyc = 0, npls = 0;

    hsfp_regs uut (.hready(hreadyout), .*);
    hsfp_ahb_master m (.hclk, .hready(hreadyout), .hrdata, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hwdata);

    always #2.5 hclk = ~hclk;
    // Every pulse bit that is high counts once per cycle, so a stretched pulse shows up.
    always @(posedge hclk)
    begin
        cyc <= cyc + 1;
        npls <= npls + $countones({sram0_single_cnt_clear, sram0_double_cnt_clear,
            sram1_single_cnt_clear, sram1_double_cnt_clear, dma_write_buf_flush,
            ahb_write_buf_flush, ahb_read_buf_invalidate, dma_read_buf_invalidate});
        if (cyc == 5000)
        begin
            num_errors++;
            test_done();
        end
    end

    task test_done;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task wr(input [11:0] a, input [31:0] d);
        reg [31:0] q;
        m.xfer(1'b1, {20'h0, a}, d, q);
    endtask
    task rc(input [11:0] a, input [31:0] e, input [31:0] k);
        reg [31:0] q;
        m.xfer(1'b0, {20'h0, a}, 32'h0, q);
        `CHK(q & k, e)
    endtask
    task fab(input [31:0] a, input e);
        fab_req <= 1'b1;
        fab_addr <= a;
        @(posedge hclk);
        fab_req <= 1'b0;
        fab_addr <= ~a;
        #1;
        `CHK(fab_prot_err, e)
        @(posedge hclk);
    endtask

    initial
    begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rc(`HSFP_OFS_IO_CAL, 32'h1ffe, 32'h1fff);
        rc(`HSFP_OFS_CLK_CAL, 32'h0, 32'hffffffff);
        rc(`HSFP_OFS_PROT_SIZE, 32'h1e, 32'hffffffff);
        rc(`HSFP_OFS_PROT_BASE, 32'h0, 32'hffffffff);
        rc(`HSFP_OFS_SRAM_ERR, 32'h0, 32'hffffffff);
        rc(`HSFP_OFS_EXT_SR, 32'h0, 32'hffffffff);
        rc(12'h030, 32'h0, 32'hffffffff);
        wr(`HSFP_OFS_PROT_SIZE, 32'hffffffff);
        rc(`HSFP_OFS_PROT_SIZE, 32'h3f, 32'hffffffff);
        wr(`HSFP_OFS_INT_SR, 32'hffffffff);
        rc(`HSFP_OFS_INT_SR, 32'h0, 32'hffffffff);
        wr(`HSFP_OFS_PROT_SIZE, 32'h0f);
        wr(`HSFP_OFS_PROT_BASE, 32'h12340001);
        fab(32'h1234fffc, 1'b1);
        fab(32'h12340000, 1'b1);
        fab(32'h12350000, 1'b0);
        fab(32'h1233fffc, 1'b0);
        wr(`HSFP_OFS_PROT_BASE, 32'h12340000);
        fab(32'h12340010, 1'b0);
        wr(`HSFP_OFS_PROT_SIZE, 32'h06);
        wr(`HSFP_OFS_PROT_BASE, 32'h12345681);
        fab(32'h12345680, 1'b1);
        fab(32'h123456fc, 1'b1);
        fab(32'h12345700, 1'b0);
        wr(`HSFP_OFS_PROT_SIZE, 32'h12);
        wr(`HSFP_OFS_PROT_BASE, 32'h00080001);
        fab(32'h000ffffc, 1'b1);
        fab(32'h00100000, 1'b0);
        wr(`HSFP_OFS_PROT_SIZE, 32'h13);
        fab(32'h00080000, 1'b0);
        wr(`HSFP_OFS_PROT_SIZE, 32'h0c);
        fab(32'h00080000, 1'b0);
        clk_en <= 1'b0;
        wr(`HSFP_OFS_PROT_SIZE, 32'h06);
        clk_en <= 1'b1;
        rc(`HSFP_OFS_PROT_SIZE, 32'h0c, 32'hffffffff);
        pullup_code_in <= 7'h2a;
        pulldown_code_in <= 5'h15;
        repeat (2) @(posedge hclk);
        rc(`HSFP_OFS_IO_CAL, 32'haaa, 32'h1fff);
        io_cal_done_irq <= 1'b1;
        repeat (2) @(posedge hclk);
        pullup_code_in <= 7'h11;
        pulldown_code_in <= 5'h03;
        rc(`HSFP_OFS_IO_CAL, 32'haab, 32'h1fff);
        io_cal_done_irq <= 1'b0;
        repeat (2) @(posedge hclk);
        io_cal_done_irq <= 1'b1;
        repeat (2) @(posedge hclk);
        rc(`HSFP_OFS_IO_CAL, 32'h446, 32'h1fff);
        fabric_cal_override <= 1'b1;
        repeat (2) @(posedge hclk);
        rc(`HSFP_OFS_IO_CAL, 32'h447, 32'h1fff);
        {fabric_cal_override, io_cal_done_irq} <= 2'h0;
        repeat (2) @(posedge hclk);
        io_cal_done_irq <= 1'b1;
        repeat (2) @(posedge hclk);
        dram_self_refresh <= 1'b1;
        repeat (2) @(posedge hclk);
        rc(`HSFP_OFS_IO_CAL, 32'h447, 32'h1fff);
        {sram_err_evt, ddr_cal_done_irq, ddr_secded_irq, ddr_fabric_if_irq} <= 7'h57;
        {main_pll_lock, fabric_pll_lock, fabric_clk_cal_failed_in} <= 3'h7;
        {dma_write_err_evt, ahb_write_err_evt, addr_match_evt, bus_err_evt} <= 10'h3ff;
        {dma_err_addr_in, ahb_err_addr_in} <= {32'hdead0010, 32'hbeef0020};
        {lock_xfer_active, lock_xfer_dma} <= 2'h3;
        @(posedge hclk);
        {sram_err_evt, ddr_cal_done_irq, ddr_secded_irq, ddr_fabric_if_irq} <= 7'h0;
        {dma_write_err_evt, ahb_write_err_evt, addr_match_evt, bus_err_evt} <= 10'h0;
        repeat (8) @(posedge hclk);
        rc(`HSFP_OFS_SRAM_ERR, 32'ha, 32'hffffffff);
        rc(`HSFP_OFS_INT_SR, 32'h75, 32'hffffffff);
        rc(`HSFP_OFS_CLK_CAL, 32'h1, 32'hffffffff);
        rc(`HSFP_OFS_EXT_SR, 32'hc0d7, 32'hffffffff);
        `CHK(dma_error_address, 32'hdead0010)
        `CHK(ahb_error_address, 32'hbeef0020)
        {main_pll_lock, fabric_pll_lock, fabric_clk_cal_failed_in} <= 3'h0;
        {sram_err_evt, lock_xfer_active} <= 5'ha;
        @(posedge hclk);
        sram_err_evt <= 4'h0;
        repeat (8) @(posedge hclk);
        rc(`HSFP_OFS_SRAM_ERR, 32'hf, 32'hffffffff);
        rc(`HSFP_OFS_INT_SR, 32'h7f, 32'hffffffff);
        rc(`HSFP_OFS_CLK_CAL, 32'h0, 32'hffffffff);
        wr(`HSFP_OFS_EXT_CLR, 32'hffffffff);
        rc(`HSFP_OFS_EXT_SR, 32'h0, 32'hffffffff);
        wr(`HSFP_OFS_INT_CLR, 32'hffffffff);
        rc(`HSFP_OFS_INT_SR, 32'h0, 32'hffffffff);
        wr(`HSFP_OFS_SRAM_CLR, 32'h5);
        rc(`HSFP_OFS_SRAM_ERR, 32'ha, 32'hffffffff);
        wr(`HSFP_OFS_CNT_CLR, 32'hf);
        wr(`HSFP_OFS_CNT_CLR, 32'h5);
        wr(`HSFP_OFS_FLUSH, 32'hd8);
        wr(`HSFP_OFS_FLUSH, 32'h27);
        repeat (3) @(posedge hclk);
        `CHK(npls, 10)
        test_done();
    end
endmodule // hsfp_regs_bench
